//--- verilog/bfoc_core.sv
// banked flash operation control: pin decode, command register, embedded engine
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - array of 4,194,304 words, 16 bits each
// - address space split into four banks
// - other banks read array during busy operation
// - chip, write, address-valid, output strobes control access
// - burst clock advances address, ready paces data
// - bus writes decode as commands, not data
// - status: polling bit, toggle bits flip
// - finished operation returns to array read
// - erase touches only its own sector
// - program voltage low locks all sectors
// - stable address for set time gives sleep
// - standby honoured when host deselects device with no program or erase active
// - program self-timed pulse then verify
// - buffered programming writes group of words
// - erase preprograms, then erases, self-timed
// - program suspend allows other reads, resume continues
// - program suspend nests inside erase suspend once
// - erase suspend allows reads, programs elsewhere
// - hardware reset aborts, returns to array read
// - low supply blocks all writes
// - low address and data share bus
// - chip and output enable act unclocked; the code registers bus_oe and bus_out, so they follow one sys_clk edge later
module bfoc_core #(
    parameter int ADDR_W = bfoc_pkg::ADDR_W,
    parameter int SECT_W = bfoc_pkg::SECT_W,
    parameter int BUF_DEPTH = bfoc_pkg::BUF_DEPTH,
    parameter int PULSE_CYC = bfoc_pkg::PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic address_valid_n,
    input wire logic burst_clk,
    input wire logic [ADDR_W-17:0] addr_hi,
    input wire logic [15:0] bus_in,
    input wire logic vpp_low,
    input wire logic supply_low,
    output logic [15:0] bus_out,
    output logic bus_oe,
    output logic rdy,
    output logic sleep,
    output logic standby
);
    localparam int BI_W = $clog2(BUF_DEPTH);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int SLW = $clog2(bfoc_pkg::SLEEP_CYC + 1);
    localparam int SN_W = ADDR_W - SECT_W;
    localparam int BW = bfoc_pkg::BANK_W;

    function automatic logic [SN_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SECT_W];
    endfunction
    function automatic logic [BW-1:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:ADDR_W-BW];
    endfunction

    // ------------------------------------------------------------
    // pin sampling and address latch
    // ------------------------------------------------------------
    logic we_q, oe_q, bclk_q;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [SLW-1:0] idle_cnt, next_idle_cnt;
    logic clr, latch, rd_on, wr_evt, rd_start, burst_adv;

    assign clr = rst | ~reset_n;
    assign latch = ~ce_n & ~address_valid_n;
    // enables are level decoded, never aligned to the burst clock
    assign rd_on = ~ce_n & ~oe_n & address_valid_n;
    assign wr_evt = ~we_q & we_n & ~ce_n & address_valid_n & ~supply_low;
    assign rd_start = oe_q & rd_on;
    assign burst_adv = ~bclk_q & burst_clk & rd_on;

    always_comb begin
        next_addr = addr;
        if (latch) begin
            next_addr = {addr_hi, bus_in};
        end else if (burst_adv) begin
            next_addr = addr + 1'b1;
        end
        if (next_addr != addr) begin
            next_idle_cnt = '0;
        end else if (idle_cnt == SLW'(bfoc_pkg::SLEEP_CYC)) begin
            next_idle_cnt = idle_cnt;
        end else begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            we_q <= 1'b1;
            oe_q <= 1'b1;
            bclk_q <= 1'b0;
            addr <= '0;
            idle_cnt <= '0;
        end else begin
            we_q <= we_n;
            oe_q <= oe_n;
            bclk_q <= burst_clk;
            addr <= next_addr;
            idle_cnt <= next_idle_cnt;
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] buf_a [0:BUF_DEPTH-1];
    logic [15:0] buf_d [0:BUF_DEPTH-1];
    logic mem_we, buf_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [15:0] mem_wd;

    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = bfoc_pkg::ERASED_WORD;
        end
    end

    // ------------------------------------------------------------
    // command register and embedded engine
    // ------------------------------------------------------------
    bfoc_pkg::bfoc_cmd_t cmd_st, next_cmd_st;
    bfoc_pkg::bfoc_pphase_t pphase, next_pphase;
    bfoc_pkg::bfoc_ephase_t ephase, next_ephase;
    logic prog_act, next_prog_act, prog_susp, next_prog_susp, buf_mode, next_buf_mode;
    logic erase_act, next_erase_act, erase_susp, next_erase_susp;
    logic fail, next_fail, tog6, next_tog6, tog2, next_tog2;
    logic [ADDR_W-1:0] prog_addr, next_prog_addr, cur_a, er_a;
    logic [15:0] prog_data, next_prog_data, cur_d, arr_word, cur_word, er_word, stat;
    logic [BI_W-1:0] buf_cnt, next_buf_cnt, buf_idx, next_buf_idx;
    logic [PW-1:0] pulse_cnt, next_pulse_cnt;
    logic [SN_W-1:0] erase_sect, next_erase_sect;
    logic [SECT_W-1:0] erase_idx, next_erase_idx;
    logic [7:0] cmd;
    logic hit_p, hit_e, status_hit, sect_ok;

    assign cur_a = buf_mode ? buf_a[buf_idx] : prog_addr;
    assign cur_d = buf_mode ? buf_d[buf_idx] : prog_data;
    assign er_a = {erase_sect, erase_idx};
    assign arr_word = mem[addr];
    assign cur_word = mem[cur_a];
    assign er_word = mem[er_a];
    assign cmd = bus_in[7:0];
    // a suspended erase sector may not be programmed
    assign sect_ok = ~erase_act | (sector_of(addr) != erase_sect);
    assign hit_p = prog_act & (bank_of(addr) == bank_of(cur_a))
        & (~prog_susp | sector_of(addr) == sector_of(cur_a));
    assign hit_e = erase_act & (bank_of(addr) == erase_sect[SN_W-1:SN_W-BW])
        & (~erase_susp | sector_of(addr) == erase_sect);
    assign status_hit = hit_p | hit_e;

    always_comb begin
        stat = '0;
        stat[bfoc_pkg::ST_POLL_BIT] = hit_p ? ~cur_d[bfoc_pkg::ST_POLL_BIT] : erase_susp;
        stat[bfoc_pkg::ST_TOG_BIT] = tog6;
        stat[bfoc_pkg::ST_FAIL_BIT] = fail;
        stat[bfoc_pkg::ST_ERASE_BIT] = erase_act;
        stat[bfoc_pkg::ST_TOG2_BIT] = tog2;
    end

    always_comb begin
        next_cmd_st = cmd_st;
        next_pphase = pphase;
        next_ephase = ephase;
        next_prog_act = prog_act;
        next_prog_susp = prog_susp;
        next_buf_mode = buf_mode;
        next_erase_act = erase_act;
        next_erase_susp = erase_susp;
        next_fail = fail;
        next_tog6 = tog6;
        next_tog2 = tog2;
        next_prog_addr = prog_addr;
        next_prog_data = prog_data;
        next_buf_cnt = buf_cnt;
        next_buf_idx = buf_idx;
        next_pulse_cnt = pulse_cnt;
        next_erase_sect = erase_sect;
        next_erase_idx = erase_idx;
        mem_we = 1'b0;
        mem_wa = er_a;
        mem_wd = bfoc_pkg::ERASED_WORD;
        buf_we = 1'b0;
        if (rd_start && status_hit) begin
            next_tog6 = ~tog6;
            next_tog2 = hit_e ? ~tog2 : tog2;
        end
        // engine stalls, never writes, while the supply is low
        if (!supply_low && prog_act && !prog_susp && !fail) begin
            if (pphase == bfoc_pkg::PP_PULSE) begin
                if (pulse_cnt == PW'(PULSE_CYC - 1)) begin
                    mem_we = 1'b1;
                    mem_wa = cur_a;
                    mem_wd = cur_word & cur_d;
                    next_pphase = bfoc_pkg::PP_VERIFY;
                end else begin
                    next_pulse_cnt = pulse_cnt + 1'b1;
                end
            end else if (cur_word != cur_d) begin
                next_fail = 1'b1;
            end else if (buf_mode && buf_idx != buf_cnt) begin
                next_buf_idx = buf_idx + 1'b1;
                next_pphase = bfoc_pkg::PP_PULSE;
                next_pulse_cnt = '0;
            end else begin
                next_prog_act = 1'b0;
            end
        end else if (!supply_low && erase_act && !erase_susp && !prog_act) begin
            // preprogram skips cells already at zero
            mem_we = (ephase == bfoc_pkg::EP_ERASE) || (er_word != bfoc_pkg::PRE_WORD);
            mem_wd = (ephase == bfoc_pkg::EP_PRE) ? bfoc_pkg::PRE_WORD : bfoc_pkg::ERASED_WORD;
            next_erase_idx = erase_idx + 1'b1;
            if (&erase_idx) begin
                next_ephase = bfoc_pkg::EP_ERASE;
                next_erase_act = (ephase == bfoc_pkg::EP_PRE);
            end
        end
        if (wr_evt) begin
            next_cmd_st = bfoc_pkg::CS_READ;
            case (cmd_st)
                bfoc_pkg::CS_READ: begin
                    if (cmd == bfoc_pkg::CMD_PROG && !prog_act && (!erase_act || erase_susp)) begin
                        next_cmd_st = bfoc_pkg::CS_PROG_DATA;
                    end else if (cmd == bfoc_pkg::CMD_BUF_LOAD && !prog_act
                            && (!erase_act || erase_susp)) begin
                        next_cmd_st = bfoc_pkg::CS_BUF_COUNT;
                    end else if (cmd == bfoc_pkg::CMD_ERASE_SETUP && !prog_act && !erase_act) begin
                        next_cmd_st = bfoc_pkg::CS_ERASE_SETUP;
                    end else if (cmd == bfoc_pkg::CMD_SUSPEND) begin
                        // only one program exists, so nesting stops at one level
                        if (prog_act && !fail) begin
                            next_prog_susp = 1'b1;
                        end else if (erase_act) begin
                            next_erase_susp = 1'b1;
                        end
                    end else if (cmd == bfoc_pkg::CMD_RESUME) begin
                        if (prog_susp) begin
                            next_prog_susp = 1'b0;
                        end else begin
                            next_erase_susp = 1'b0;
                        end
                    end else if (cmd == bfoc_pkg::CMD_READ_ARRAY && fail) begin
                        next_fail = 1'b0;
                        next_prog_act = 1'b0;
                    end
                end
                bfoc_pkg::CS_PROG_DATA: begin
                    if (!vpp_low && sect_ok) begin
                        next_prog_act = 1'b1;
                        next_buf_mode = 1'b0;
                        next_prog_addr = addr;
                        next_prog_data = bus_in;
                        next_pphase = bfoc_pkg::PP_PULSE;
                        next_pulse_cnt = '0;
                    end
                end
                bfoc_pkg::CS_ERASE_SETUP: begin
                    if (cmd == bfoc_pkg::CMD_SECT_ERASE && !vpp_low) begin
                        next_erase_act = 1'b1;
                        next_erase_sect = sector_of(addr);
                        next_erase_idx = '0;
                        next_ephase = bfoc_pkg::EP_PRE;
                    end
                end
                bfoc_pkg::CS_BUF_COUNT: begin
                    if (bus_in < 16'(BUF_DEPTH)) begin
                        next_buf_cnt = bus_in[BI_W-1:0];
                        next_buf_idx = '0;
                        next_cmd_st = bfoc_pkg::CS_BUF_LOAD;
                    end
                end
                bfoc_pkg::CS_BUF_LOAD: begin
                    if (sect_ok) begin
                        buf_we = 1'b1;
                        next_buf_idx = buf_idx + 1'b1;
                        next_cmd_st = (buf_idx == buf_cnt) ? bfoc_pkg::CS_BUF_CONFIRM
                            : bfoc_pkg::CS_BUF_LOAD;
                    end
                end
                bfoc_pkg::CS_BUF_CONFIRM: begin
                    if (cmd == bfoc_pkg::CMD_BUF_CONFIRM && !vpp_low) begin
                        next_prog_act = 1'b1;
                        next_buf_mode = 1'b1;
                        next_buf_idx = '0;
                        next_pphase = bfoc_pkg::PP_PULSE;
                        next_pulse_cnt = '0;
                    end
                end
                default: next_cmd_st = bfoc_pkg::CS_READ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            cmd_st <= bfoc_pkg::CS_READ;
            pphase <= bfoc_pkg::PP_PULSE;
            ephase <= bfoc_pkg::EP_PRE;
            prog_act <= 1'b0;
            prog_susp <= 1'b0;
            buf_mode <= 1'b0;
            erase_act <= 1'b0;
            erase_susp <= 1'b0;
            fail <= 1'b0;
            tog6 <= 1'b0;
            tog2 <= 1'b0;
            prog_addr <= '0;
            prog_data <= '0;
            buf_cnt <= '0;
            buf_idx <= '0;
            pulse_cnt <= '0;
            erase_sect <= '0;
            erase_idx <= '0;
        end else begin
            cmd_st <= next_cmd_st;
            pphase <= next_pphase;
            ephase <= next_ephase;
            prog_act <= next_prog_act;
            prog_susp <= next_prog_susp;
            buf_mode <= next_buf_mode;
            erase_act <= next_erase_act;
            erase_susp <= next_erase_susp;
            fail <= next_fail;
            tog6 <= next_tog6;
            tog2 <= next_tog2;
            prog_addr <= next_prog_addr;
            prog_data <= next_prog_data;
            buf_cnt <= next_buf_cnt;
            buf_idx <= next_buf_idx;
            pulse_cnt <= next_pulse_cnt;
            erase_sect <= next_erase_sect;
            erase_idx <= next_erase_idx;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we && !clr) begin
            mem[mem_wa] <= mem_wd;
        end
        if (buf_we && !clr) begin
            buf_a[buf_idx] <= addr;
            buf_d[buf_idx] <= bus_in;
        end
    end

    // ------------------------------------------------------------
    // read path and power state outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            bus_out <= '0;
            bus_oe <= 1'b0;
            rdy <= 1'b0;
            sleep <= 1'b0;
            standby <= 1'b0;
        end else begin
            bus_out <= status_hit ? stat : arr_word;
            bus_oe <= rd_on;
            rdy <= rd_on & ~burst_adv;
            sleep <= (next_idle_cnt == SLW'(bfoc_pkg::SLEEP_CYC));
            standby <= ce_n & ~prog_act & ~erase_act;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (clr);

    property p_oe; bus_oe |-> $past(rd_on); endproperty
    a_oe: assert property (p_oe) else $error("bus driven without read strobes");
    property p_rdy; rdy |-> bus_oe; endproperty
    a_rdy: assert property (p_rdy) else $error("ready without bus drive");
    property p_cmd; mem_we |-> prog_act || erase_act; endproperty
    a_cmd: assert property (p_cmd) else $error("array written by bus cycle");
    property p_tog; rd_start && status_hit |=> tog6 != $past(tog6); endproperty
    a_tog: assert property (p_tog) else $error("toggle bit did not flip");
    property p_idle; !prog_act && !erase_act |-> !status_hit; endproperty
    a_idle: assert property (p_idle) else $error("status shown while idle");
    property p_sect; mem_we && !prog_act |-> sector_of(mem_wa) == erase_sect; endproperty
    a_sect: assert property (p_sect) else $error("erase left its sector");
    property p_vpp; $rose(prog_act) || $rose(erase_act) |-> !$past(vpp_low); endproperty
    a_vpp: assert property (p_vpp) else $error("operation started while locked");
    property p_sup; mem_we |-> !supply_low; endproperty
    a_sup: assert property (p_sup) else $error("write during low supply");
    property p_arr; rd_on && !status_hit |=> bus_out == $past(arr_word); endproperty
    a_arr: assert property (p_arr) else $error("array read delayed or wrong");
    property p_busy; prog_act && !prog_susp && bank_of(addr) == bank_of(cur_a) |-> status_hit;
    endproperty
    a_busy: assert property (p_busy) else $error("busy bank returned array");

    c_prog: cover property ($fell(prog_act) && !fail);
    c_esusp: cover property (erase_susp && prog_act);
    c_nest: cover property (erase_susp && prog_susp);
endmodule
`default_nettype wire

//--- verilog/bfoc_pkg.sv
// constants, command codes and state types of the banked flash operation control
package bfoc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int BANK_W = 2;
    localparam int SECT_W = 15;
    localparam int BUF_DEPTH = 32;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [15:0] PRE_WORD = 16'h0000;
    // ------------------------------------------------------------
    // command codes, low byte of a write cycle
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
    localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h3a;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hf0;
    // ------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------
    localparam int ST_POLL_BIT = 7;
    localparam int ST_TOG_BIT = 6;
    localparam int ST_FAIL_BIT = 5;
    localparam int ST_ERASE_BIT = 3;
    localparam int ST_TOG2_BIT = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int SLEEP_NS = 150;
    localparam int SLEEP_CYC = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = 4;
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_READ = 3'h0,
        CS_PROG_DATA = 3'h1,
        CS_ERASE_SETUP = 3'h2,
        CS_BUF_COUNT = 3'h3,
        CS_BUF_LOAD = 3'h4,
        CS_BUF_CONFIRM = 3'h5
    } bfoc_cmd_t;
    typedef enum logic [0:0] {EP_PRE = 1'h0, EP_ERASE = 1'h1} bfoc_ephase_t;
    typedef enum logic [0:0] {PP_PULSE = 1'h0, PP_VERIFY = 1'h1} bfoc_pphase_t;
endpackage

//--- testbench/bfoc_host.sv
// host bus master model driving the multiplexed flash pins
`timescale 1ns/1ps
`default_nettype none
module bfoc_host (
    input wire logic sys_clk,
    input wire logic rdy,
    input wire logic bus_oe,
    input wire logic [15:0] bus_out,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic address_valid_n,
    output logic burst_clk,
    output logic [1:0] addr_hi,
    output var logic [15:0] bus_in
);
    logic drive = 1'b0;
    logic [15:0] val = 16'h0000;
    // released bus shows the inverse, so a stale word never passes
    assign bus_in = drive ? val : (bus_oe ? bus_out : ~val);
    initial begin
        {ce_n, we_n, oe_n, address_valid_n} = 4'hf;
        burst_clk = 1'b0;
        addr_hi = 2'h0;
    end
    task automatic adr(input logic [17:0] a);
        @(posedge sys_clk);
        #1;
        {ce_n, address_valid_n, drive} = 3'h1;
        {addr_hi, val} = a;
        @(posedge sys_clk);
        #1;
        address_valid_n = 1'b1;
    endtask
    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        adr(a);
        val = d;
        we_n = 1'b0;
        @(posedge sys_clk);
        #1;
        we_n = 1'b1;
        @(posedge sys_clk);
        #1;
        ce_n = 1'b1;
        drive = 1'b0;
    endtask
    // burst read of two words: one rising burst clock between them
    task automatic brd(input logic [17:0] a, output logic [15:0] d0, output logic [15:0] d);
        adr(a);
        drive = 1'b0;
        oe_n = 1'b0;
        @(posedge sys_clk);
        #1;
        d0 = rdy ? bus_out : ~bus_out;
        burst_clk = 1'b1;
        @(posedge sys_clk);
        #1;
        burst_clk = 1'b0;
        @(posedge sys_clk);
        #1;
        d = rdy ? bus_out : ~bus_out;
        oe_n = 1'b1;
        ce_n = 1'b1;
    endtask
    task automatic rd(input logic [17:0] a, output logic [15:0] d, output int n);
        logic ok;
        adr(a);
        drive = 1'b0;
        oe_n = 1'b0;
        ok = 1'b0;
        n = 0;
        while (n < 8 && ok !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            ok = rdy & bus_oe;
            n++;
        end
        d = bus_out;
        oe_n = 1'b1;
        ce_n = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- testbench/banked_flash_operation_control_bench.sv
// self-checking bench of the banked flash operation control
`timescale 1ns/1ps
`default_nettype none
module banked_flash_operation_control_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_n = 1'b1;
    logic vpp_low = 1'b0;
    logic supply_low = 1'b0;
    wire logic ce_n, we_n, oe_n, avn, bclk, bus_oe, rdy, sleep, standby;
    wire logic [1:0] addr_hi;
    wire logic [15:0] bus_in, bus_out;
    logic [15:0] d1, d2;
    int n;
    int bad_count = 0;
    int check_count = 0;
    always #20 sys_clk = ~sys_clk;
    // long pulse keeps the program busy across several status reads
    bfoc_core #(.ADDR_W(18), .SECT_W(4), .BUF_DEPTH(32), .PULSE_CYC(20)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .reset_n(reset_n), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .address_valid_n(avn), .burst_clk(bclk), .addr_hi(addr_hi),
        .bus_in(bus_in), .vpp_low(vpp_low), .supply_low(supply_low), .bus_out(bus_out),
        .bus_oe(bus_oe), .rdy(rdy), .sleep(sleep), .standby(standby));
    bfoc_host host_u (
        .sys_clk(sys_clk), .rdy(rdy), .bus_oe(bus_oe), .bus_out(bus_out), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .address_valid_n(avn), .burst_clk(bclk),
        .addr_hi(addr_hi), .bus_in(bus_in));
    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [17:0] a, input logic [15:0] exp);
        host_u.rd(a, d1, n);
        chk("array word", d1, exp);
        chk("read wait", 16'(n), 16'h0001);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #120000;
        bad_count++;
        report_and_stop();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        cyc(12);
        rst = 1'b0;
        rchk(18'h00005, 16'hffff);
        host_u.wr(18'h00003, 16'h00a0);
        host_u.wr(18'h00003, 16'h1234);
        host_u.rd(18'h00003, d1, n);
        host_u.rd(18'h00003, d2, n);
        chk("poll bit", {15'h0000, d1[7]}, 16'h0001);
        chk("toggle bit", {15'h0000, d1[6] ^ d2[6]}, 16'h0001);
        rchk(18'h10003, 16'hffff);
        chk("ready wait", 16'(n), 16'h0001);
        cyc(30);
        rchk(18'h00003, 16'h1234);
        host_u.wr(18'h00010, 16'h00a0);
        host_u.wr(18'h00010, 16'h5678);
        cyc(30);
        host_u.wr(18'h00000, 16'h0080);
        host_u.wr(18'h00000, 16'h0030);
        host_u.rd(18'h00003, d1, n);
        chk("erase busy", {15'h0000, d1[3]}, 16'h0001);
        cyc(60);
        rchk(18'h00003, 16'hffff);
        rchk(18'h00010, 16'h5678);
        vpp_low = 1'b1;
        host_u.wr(18'h00020, 16'h00a0);
        host_u.wr(18'h00020, 16'h0000);
        rchk(18'h00020, 16'hffff);
        vpp_low = 1'b0;
        supply_low = 1'b1;
        host_u.wr(18'h00021, 16'h00a0);
        host_u.wr(18'h00021, 16'h0000);
        supply_low = 1'b0;
        cyc(30);
        rchk(18'h00021, 16'hffff);
        host_u.wr(18'h00030, 16'h00a0);
        host_u.wr(18'h00030, 16'h00ab);
        cyc(30);
        host_u.wr(18'h00020, 16'h0080);
        host_u.wr(18'h00020, 16'h0030);
        cyc(5);
        reset_n = 1'b0;
        cyc(1);
        reset_n = 1'b1;
        rchk(18'h00030, 16'h00ab);
        host_u.wr(18'h00040, 16'h0080);
        host_u.wr(18'h00040, 16'h0030);
        // suspended host stays out of special areas
        host_u.wr(18'h00040, 16'h00b0);
        host_u.wr(18'h00051, 16'h00a0);
        host_u.wr(18'h00051, 16'h00c3);
        cyc(30);
        rchk(18'h00051, 16'h00c3);
        host_u.rd(18'h00041, d1, n);
        chk("erase suspended", {15'h0000, d1[7]}, 16'h0001);
        host_u.wr(18'h00040, 16'h003a);
        cyc(60);
        rchk(18'h00041, 16'hffff);
        host_u.wr(18'h00060, 16'h00a0);
        host_u.wr(18'h00060, 16'h0f0f);
        host_u.wr(18'h00060, 16'h00b0);
        rchk(18'h00010, 16'h5678);
        host_u.wr(18'h00060, 16'h003a);
        cyc(40);
        rchk(18'h00060, 16'h0f0f);
        // two-word buffer: count field holds words minus one
        host_u.wr(18'h00070, 16'h0025);
        host_u.wr(18'h00070, 16'h0001);
        host_u.wr(18'h00070, 16'h1111);
        host_u.wr(18'h00071, 16'h2222);
        host_u.wr(18'h00070, 16'h0029);
        cyc(60);
        host_u.brd(18'h00070, d1, d2);
        chk("buffer word 0", d1, 16'h1111);
        chk("burst word 1", d2, 16'h2222);
        cyc(10);
        chk("sleep", {15'h0000, sleep}, 16'h0001);
        chk("standby", {15'h0000, standby}, 16'h0001);
        report_and_stop();
    end
endmodule
`default_nettype wire
